// ===== hw/icm_map.svh
// Register offsets, line tables and reset values of the interrupt matrix
`ifndef ICM_MAP_SVH
`define ICM_MAP_SVH

// Byte offsets of the register regions
`define ICM_ROUTE0_BASE     12'h000
`define ICM_ROUTE1_BASE     12'h200
`define ICM_ROUTE_SPAN      12'h200
`define ICM_STATE0_BASE     12'h400
`define ICM_STATE1_BASE     12'h420
`define ICM_STATE_SPAN      12'h020
`define ICM_LINE_EDGE       12'h440
`define ICM_LINE_INTERNAL   12'h444
`define ICM_PRIO_BASE       12'h450
`define ICM_PRIO_SPAN       12'h010
`define ICM_NMI_MASK_STATE  12'h460
`define ICM_LINES0_STATE    12'h470
`define ICM_LINES1_STATE    12'h474

// Line classes, one bit per core line
`define ICM_PERIPH_LINES    32'hdffe773f
`define ICM_INTERNAL_LINES  32'h200188c0
`define ICM_EDGE_LINES      32'h50400400
`define ICM_NMI_LINE        5'h0e

// Priority per line, one nibble each, line 0 lowest; 7 marks the NMI
`define ICM_PRIO_TABLE      128'h54343544_33222115_37113111_11111111

// Route value after reset: an internal line, so the source is cut off
`define ICM_ROUTE_RESET     5'h06

// Fixed widths
`define ICM_LINE_BITS       5
`define ICM_WORD_BITS       32
`define ICM_ADDR_BITS       12

`endif

// ===== hw/icm_pkg.sv
// Types shared by the interrupt matrix files
`include "icm_map.svh"

package icm_pkg;

  typedef logic [`ICM_LINE_BITS-1:0] icm_line_t;

  // Avalon-MM request from the bus master
  typedef struct packed {
    logic [`ICM_ADDR_BITS-1:0] address;
    logic                      read;
    logic                      write;
    logic [`ICM_WORD_BITS-1:0] writedata;
    logic [3:0]                byteenable;
  } icm_av_req_t;

  // Avalon-MM answer to the bus master
  typedef struct packed {
    logic [`ICM_WORD_BITS-1:0] readdata;
    logic                      waitrequest;
  } icm_av_rsp_t;

  // Slave handshake states
  typedef enum logic [1:0] {
    ICM_BUS_IDLE = 2'b01,
    ICM_BUS_DONE = 2'b10
  } icm_bus_state_t;

endpackage

// ===== hw/icm_route_unit.sv
// Routing of all sources onto the 32 lines of one core
`timescale 1ns/100ps
`default_nettype none
`include "icm_map.svh"

module icm_route_unit #(
  parameter int NUM_SRC = 69
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Sources, their routing and the NMI mask for this core
  input  wire logic [NUM_SRC-1:0]       sources,
  input  wire logic [NUM_SRC*5-1:0]     routes,
  input  wire logic                     nmi_mask,
  // Core lines
  output logic [31:0]                   lines_q
);
  import icm_pkg::*;

  logic [31:0] lines_d;
  logic [31:0] periph;

  assign periph = `ICM_PERIPH_LINES;

  always_comb begin
    icm_line_t tgt;
    tgt     = '0;
    lines_d = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      tgt = routes[s*`ICM_LINE_BITS +: `ICM_LINE_BITS];
      // Internal targets fall out here, whichever one is chosen
      if (periph[tgt]) begin
        lines_d[tgt] = lines_d[tgt] | sources[s];
      end
    end
    // Mask lifts as soon as the controller drops the signal
    if (nmi_mask) begin
      lines_d[`ICM_NMI_LINE] = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lines_q <= '0;
    end else begin
      lines_q <= lines_d;
    end
  end

endmodule

`default_nettype wire

// ===== hw/icm_matrix.sv
// Dual-core interrupt matrix with its Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
`include "icm_map.svh"

module icm_matrix #(
  parameter int NUM_SRC = 69
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Register bus
  input  wire icm_pkg::icm_av_req_t av_req,
  output icm_pkg::icm_av_rsp_t      av_rsp_q,
  // Peripheral sources
  input  wire logic [NUM_SRC-1:0]   sources,
  // Masks from the process_id_controller
  input  wire logic                 first_core_nmi_mask,
  input  wire logic                 second_core_nmi_mask,
  // Core lines
  output logic [31:0]               first_core_lines,
  output logic [31:0]               second_core_lines
);
  import icm_pkg::*;

  localparam int NUM_WORDS = (NUM_SRC + 31) / 32;
  localparam int PAD_BITS  = NUM_WORDS * 32;

  // Route settings, one per source and core
  icm_line_t first_core_source_route_q  [NUM_SRC];
  icm_line_t second_core_source_route_q [NUM_SRC];
  logic [NUM_SRC*5-1:0] first_routes;
  logic [NUM_SRC*5-1:0] second_routes;

  // Bus handshake
  icm_bus_state_t        bus_q;
  logic                  access;
  logic                  wr_take;
  logic [31:0]           rd_d;
  logic [`ICM_ADDR_BITS-1:0] addr;
  logic [`ICM_ADDR_BITS-1:0] rel;
  logic [`ICM_ADDR_BITS-3:0] ridx;

  // Source states padded to whole words
  logic [PAD_BITS-1:0]   state_pad;
  logic [127:0]          prio_tab;

  assign access    = av_req.read | av_req.write;
  assign addr      = av_req.address;
  assign state_pad = {{(PAD_BITS-NUM_SRC){1'b0}}, sources};
  assign prio_tab  = `ICM_PRIO_TABLE;

  // One wait cycle, then the transfer completes; write lands on that edge
  assign wr_take = av_req.write & (bus_q == ICM_BUS_DONE);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_q <= ICM_BUS_IDLE;
    end else begin
      unique case (bus_q)
        ICM_BUS_IDLE: begin
          if (access) begin
            bus_q <= ICM_BUS_DONE;
          end
        end
        ICM_BUS_DONE: begin
          bus_q <= ICM_BUS_IDLE;
        end
        default: begin
          bus_q <= ICM_BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest rests high so a new request is always held one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      av_rsp_q.waitrequest <= 1'b1;
    end else begin
      av_rsp_q.waitrequest <= ~(access & (bus_q == ICM_BUS_IDLE));
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      av_rsp_q.readdata <= '0;
    end else if (av_req.read & (bus_q == ICM_BUS_IDLE)) begin
      av_rsp_q.readdata <= rd_d;
    end
  end

  // Route writes: low byte lane carries the line number
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        first_core_source_route_q[s] <= `ICM_ROUTE_RESET;
      end
    end else if (wr_take && av_req.byteenable[0] &&
                 addr >= `ICM_ROUTE0_BASE &&
                 addr <  `ICM_ROUTE0_BASE + `ICM_ROUTE_SPAN) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (addr[`ICM_ADDR_BITS-1:2] ==
            (`ICM_ROUTE0_BASE >> 2) + s[`ICM_ADDR_BITS-3:0]) begin
          // Any 5-bit number is kept; internal ones disconnect
          first_core_source_route_q[s] <=
            av_req.writedata[`ICM_LINE_BITS-1:0];
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        second_core_source_route_q[s] <= `ICM_ROUTE_RESET;
      end
    end else if (wr_take && av_req.byteenable[0] &&
                 addr >= `ICM_ROUTE1_BASE &&
                 addr <  `ICM_ROUTE1_BASE + `ICM_ROUTE_SPAN) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (addr[`ICM_ADDR_BITS-1:2] ==
            (`ICM_ROUTE1_BASE >> 2) + s[`ICM_ADDR_BITS-3:0]) begin
          second_core_source_route_q[s] <=
            av_req.writedata[`ICM_LINE_BITS-1:0];
        end
      end
    end
  end

  // Flatten the settings for the routing units
  always_comb begin
    first_routes  = '0;
    second_routes = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      first_routes[s*`ICM_LINE_BITS +: `ICM_LINE_BITS] =
        first_core_source_route_q[s];
      second_routes[s*`ICM_LINE_BITS +: `ICM_LINE_BITS] =
        second_core_source_route_q[s];
    end
  end

  // Read decode; unmapped addresses read as zero
  always_comb begin
    rd_d = '0;
    rel  = '0;
    ridx = '0;
    if (addr < `ICM_ROUTE0_BASE + `ICM_ROUTE_SPAN) begin
      ridx = addr[`ICM_ADDR_BITS-1:2];
      for (int s = 0; s < NUM_SRC; s++) begin
        if (ridx == s[`ICM_ADDR_BITS-3:0]) begin
          rd_d = {27'h0, first_core_source_route_q[s]};
        end
      end
    end else if (addr < `ICM_ROUTE1_BASE + `ICM_ROUTE_SPAN) begin
      rel  = addr - `ICM_ROUTE1_BASE;
      ridx = rel[`ICM_ADDR_BITS-1:2];
      for (int s = 0; s < NUM_SRC; s++) begin
        if (ridx == s[`ICM_ADDR_BITS-3:0]) begin
          rd_d = {27'h0, second_core_source_route_q[s]};
        end
      end
    end else if ((addr >= `ICM_STATE0_BASE &&
                  addr <  `ICM_STATE0_BASE + `ICM_STATE_SPAN) ||
                 (addr >= `ICM_STATE1_BASE &&
                  addr <  `ICM_STATE1_BASE + `ICM_STATE_SPAN)) begin
      // Both cores see the same raw source levels
      rel  = (addr < `ICM_STATE1_BASE) ? addr - `ICM_STATE0_BASE
                                       : addr - `ICM_STATE1_BASE;
      ridx = rel[`ICM_ADDR_BITS-1:2];
      for (int w = 0; w < NUM_WORDS; w++) begin
        if (ridx == w[`ICM_ADDR_BITS-3:0]) begin
          rd_d = state_pad[w*32 +: 32];
        end
      end
    end else if (addr == `ICM_LINE_EDGE) begin
      rd_d = `ICM_EDGE_LINES;
    end else if (addr == `ICM_LINE_INTERNAL) begin
      rd_d = `ICM_INTERNAL_LINES;
    end else if (addr >= `ICM_PRIO_BASE &&
                 addr <  `ICM_PRIO_BASE + `ICM_PRIO_SPAN) begin
      rel  = addr - `ICM_PRIO_BASE;
      ridx = rel[`ICM_ADDR_BITS-1:2];
      for (int w = 0; w < 4; w++) begin
        if (ridx == w[`ICM_ADDR_BITS-3:0]) begin
          rd_d = prio_tab[w*32 +: 32];
        end
      end
    end else if (addr == `ICM_NMI_MASK_STATE) begin
      rd_d = {30'h0, second_core_nmi_mask, first_core_nmi_mask};
    end else if (addr == `ICM_LINES0_STATE) begin
      rd_d = first_core_lines;
    end else if (addr == `ICM_LINES1_STATE) begin
      rd_d = second_core_lines;
    end
  end

  // One routing unit per core, each with its own mask
  icm_route_unit #(
    .NUM_SRC  (NUM_SRC)
  ) u_first_core (
    .clock    (clock),
    .rst      (rst),
    .sources  (sources),
    .routes   (first_routes),
    .nmi_mask (first_core_nmi_mask),
    .lines_q  (first_core_lines)
  );

  icm_route_unit #(
    .NUM_SRC  (NUM_SRC)
  ) u_second_core (
    .clock    (clock),
    .rst      (rst),
    .sources  (sources),
    .routes   (second_routes),
    .nmi_mask (second_core_nmi_mask),
    .lines_q  (second_core_lines)
  );

endmodule

`default_nettype wire

// ===== tb/icm_src_model.sv
// Model of the peripheral sources and the mask controller
`timescale 1ns/100ps
`default_nettype none

module icm_src_model #(
  parameter int NUM_SRC = 69
) (
  // Clock
  input  wire logic               clock,
  // Bench commands
  input  wire logic [NUM_SRC-1:0] src_cmd,
  input  wire logic [1:0]         mask_cmd,
  // Drive toward the matrix
  output logic [NUM_SRC-1:0]      sources,
  output logic [1:0]              nmi_mask
);
  // Registered, so every change lands just after an edge
  always_ff @(posedge clock) begin
    sources  <= src_cmd;
    nmi_mask <= mask_cmd;
  end
endmodule

`default_nettype wire

// ===== tb/icm_matrix_asserts.sv
// Port checks of the interrupt matrix
`timescale 1ns/100ps
`default_nettype none

module icm_matrix_chk #(
  parameter int NUM_SRC = 69
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // Register bus
  input  wire icm_pkg::icm_av_req_t av_req,
  input  wire icm_pkg::icm_av_rsp_t av_rsp_q,
  // Sources, masks, lines
  input  wire logic [NUM_SRC-1:0]   sources,
  input  wire logic                 first_core_nmi_mask,
  input  wire logic                 second_core_nmi_mask,
  input  wire logic [31:0]          first_core_lines,
  input  wire logic [31:0]          second_core_lines
);
  import icm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic rd_idle;
  assign rd_idle = av_req.read & av_rsp_q.waitrequest;

  int_lines_a: assert property (
    ((first_core_lines | second_core_lines) & 32'h200188c0) == 32'h0)
    else $error("internal line driven");
  idle_lines_a: assert property (
    sources == '0 |=> (first_core_lines | second_core_lines) == 32'h0)
    else $error("line high with no source");
  mask_first_a: assert property (
    first_core_nmi_mask |=> !first_core_lines[14])
    else $error("first core nmi not masked");
  mask_second_a: assert property (
    second_core_nmi_mask |=> !second_core_lines[14])
    else $error("second core nmi not masked");
  bus_take_a: assert property (
    (av_req.read | av_req.write) && av_rsp_q.waitrequest
    |=> !av_rsp_q.waitrequest) else $error("request not taken");
  wait_pulse_a: assert property (
    !av_rsp_q.waitrequest |=> av_rsp_q.waitrequest)
    else $error("waitrequest low too long");
  state_low_a: assert property (
    rd_idle && av_req.address == 12'h400
    |=> av_rsp_q.readdata == $past(sources[31:0]))
    else $error("state word 0 wrong");
  state_top_a: assert property (
    rd_idle && av_req.address == 12'h408
    |=> av_rsp_q.readdata[4:0] == $past(sources[68:64]))
    else $error("state word 2 wrong");

  cover property (first_core_nmi_mask && sources != '0);
  cover property (av_req.write && !av_rsp_q.waitrequest);
  cover property (second_core_lines[31]);
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Directed bench of the interrupt matrix
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import icm_pkg::*;
  logic        clock, rst;
  icm_av_req_t req;
  icm_av_rsp_t rsp;
  logic [68:0] src_cmd, sources;
  logic [1:0]  mask_cmd, nmi;
  logic [31:0] l0, l1;
  int          fail_count, total_checks;

  icm_src_model #(.NUM_SRC(69)) src_u (.clock(clock), .src_cmd(src_cmd),
    .mask_cmd(mask_cmd), .sources(sources), .nmi_mask(nmi));
  icm_matrix #(.NUM_SRC(69)) dut_u (.clock(clock), .rst(rst),
    .av_req(req), .av_rsp_q(rsp), .sources(sources),
    .first_core_nmi_mask(nmi[0]), .second_core_nmi_mask(nmi[1]),
    .first_core_lines(l0), .second_core_lines(l1));

  always #4 clock = ~clock;

  task automatic end_sim();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low; bounded wait
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    req.address <= a;
    req.write <= wr;
    req.read <= !wr;
    req.writedata <= d;
    // Read at the rising edge, ahead of the slave's own update
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (rsp.waitrequest === 1'b0) break;
    end
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n == 20) begin
      $display("[FAIL] bus timeout exp 0 got 1");
      fail_count++;
      end_sim();
    end
  endtask

  // Model edge plus matrix edge, then one spare
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, 12'h000, 32'h0, q);
    chk("route first", 32'h6, q);
    bus(1'b0, 12'h310, 32'h0, q);
    chk("route second", 32'h6, q);
    chk("lines", 32'h0, l0 | l1);
  endtask

  // Every line number on both cores, the two routes kept apart
  task automatic t_route();
    logic [31:0] q, p;
    p = ~32'h200188c0;
    src_cmd <= 69'h1 << 53;
    for (int l = 0; l < 32; l++) begin
      bus(1'b1, 12'h0d4, 32'(l), q);
      bus(1'b1, 12'h2d4, 32'(l ^ 1), q);
      bus(1'b0, 12'h0d4, 32'h0, q);
      chk("route back", 32'(l), q);
      settle();
      chk("first", p & (32'h1 << l), l0);
      chk("second", p & (32'h1 << (l ^ 1)), l1);
    end
  endtask

  task automatic t_or();
    logic [31:0] q;
    bus(1'b1, 12'h0f0, 32'd22, q);
    bus(1'b1, 12'h104, 32'd22, q);
    src_cmd <= 69'h1 << 65;
    settle();
    chk("or b", 32'h400000, l0);
    @(posedge clock);
    src_cmd <= 69'h1 << 60;
    settle();
    chk("or a", 32'h400000, l0);
  endtask

  task automatic t_nmi();
    logic [31:0] q;
    bus(1'b1, 12'h108, 32'd14, q);
    bus(1'b1, 12'h308, 32'd14, q);
    for (int m = 1; m < 4; m++) begin
      @(posedge clock);
      src_cmd <= 69'h1 << 66;
      mask_cmd <= 2'(m);
      settle();
      chk("nmi first", 32'(m[0] == 0) << 14, l0);
      chk("nmi second", 32'(m[1] == 0) << 14, l1);
    end
    @(posedge clock);
    mask_cmd <= 2'b00;
    settle();
    chk("nmi lift", 32'h4000, l0 & l1);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic [31:0] pr[4] = '{32'h11111111, 32'h37113111,
                           32'h33222115, 32'h54343544};
    @(posedge clock);
    src_cmd <= {5'h11, 32'h89abcdef, 32'h01234567};
    settle();
    bus(1'b0, 12'h400, 32'h0, q);
    chk("state 0", 32'h01234567, q);
    bus(1'b0, 12'h404, 32'h0, q);
    chk("state 1", 32'h89abcdef, q);
    bus(1'b0, 12'h408, 32'h0, q);
    chk("state 2", 32'h11, q);
    bus(1'b0, 12'h428, 32'h0, q);
    chk("state 2b", 32'h11, q);
    bus(1'b1, 12'h440, 32'h0, q);
    bus(1'b0, 12'h440, 32'h0, q);
    chk("edge", 32'h50400400, q);
    bus(1'b0, 12'h444, 32'h0, q);
    chk("internal", 32'h200188c0, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 12'h450 + 12'(4 * i), 32'h0, q);
      chk("prio", pr[i], q);
    end
    bus(1'b0, 12'hffc, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    req = '0;
    req.byteenable = 4'hf;
    src_cmd = '0;
    mask_cmd = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_or();
    t_nmi();
    t_regs();
    end_sim();
  end
endmodule

bind icm_matrix icm_matrix_chk #(.NUM_SRC(NUM_SRC)) chk_u (.clock(clock),
  .rst(rst), .av_req(av_req), .av_rsp_q(av_rsp_q), .sources(sources),
  .first_core_nmi_mask(first_core_nmi_mask),
  .second_core_nmi_mask(second_core_nmi_mask),
  .first_core_lines(first_core_lines),
  .second_core_lines(second_core_lines));

`default_nettype wire
